// ---- src/crc_ctrl.sv ----
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - idle-halt bit set stops fifo pops and shifting during idle
// - report valid fifo word count, 5 bits
// - depth 8 when length above 7, else 16
// - full flag high at maximum word count
// - empty flag high with no words, resets high
// - go bit starts shifting fifo data out
module crc_ctrl
    import crc_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic cpu_idle_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic irq_o
);
    logic [15:0] fifo_mem [16];
    logic [3:0] wptr_ff;
    logic [3:0] rptr_ff;
    logic [4:0] count_ff;
    logic idle_halt_ff;
    logic go_ff;
    logic [3:0] plen_ff;
    logic [15:0] xor_ff;
    logic [15:0] crc_ff;
    logic [15:0] shreg_ff;
    logic [3:0] bitcnt_ff;
    crc_state_type state_ff;
    logic [CRC_IRQ_W-1:0] istat_ff;
    logic [CRC_IRQ_W-1:0] imask_ff;
    logic [15:0] rdata_ff;
    logic irq_ff;

    // a word always holds plen+1 bits; order sets both width and taps
    wire logic [4:0] order = {1'b0, plen_ff} + 5'h01;
    wire logic [4:0] depth = (plen_ff >= CRC_PLEN_WIDE_MIN) ? CRC_DEPTH_WIDE
                                                            : CRC_DEPTH_NARROW;
    wire logic full = (count_ff >= depth);
    wire logic empty = (count_ff == 5'h00);
    wire logic run_en = !(idle_halt_ff && cpu_idle_i);
    wire logic wr_con = wr_i && (addr_i == CRC_OFF_CON);
    wire logic wr_data = wr_i && (addr_i == CRC_OFF_DATA);
    wire logic wr_xor = wr_i && (addr_i == CRC_OFF_XOR);
    wire logic wr_res = wr_i && (addr_i == CRC_OFF_RESULT);
    wire logic wr_istat = wr_i && (addr_i == CRC_OFF_IRQ_STAT);
    wire logic wr_imask = wr_i && (addr_i == CRC_OFF_IRQ_MASK);
    // writes into a full fifo are dropped rather than overwriting data
    wire logic push = wr_data && !full;
    wire logic pop = run_en && (state_ff == CRC_ST_IDLE) && go_ff && !empty;
    wire logic shift_step = (state_ff == CRC_ST_SHIFT) && run_en && !wr_res;
    wire logic last_bit = shift_step && ({1'b0, bitcnt_ff} == order - 5'h01);
    wire logic shift_done = last_bit && empty;
    wire logic [15:0] tap_mask = 16'hFFFF >> (5'h10 - order);
    wire logic feedback = crc_ff[order[3:0] - 4'h1] ^ shreg_ff[order[3:0] - 4'h1];
    wire logic [15:0] crc_shift = ({crc_ff[14:0], 1'b0}
                                   ^ (feedback ? xor_ff : 16'h0000)) & tap_mask;
    wire logic [15:0] con_rd = {2'b00, idle_halt_ff, count_ff, full, empty, 1'b0,
                                go_ff, plen_ff};
    // a push beside the last pop keeps the fifo filled, so no empty event
    wire logic [CRC_IRQ_W-1:0] ev = {pop && !push && (count_ff == 5'h01), shift_done};
    logic [15:0] rd_mux;

    always_comb begin
        case (addr_i)
            CRC_OFF_CON: rd_mux = con_rd;
            CRC_OFF_RESULT: rd_mux = crc_ff;
            CRC_OFF_XOR: rd_mux = xor_ff;
            CRC_OFF_IRQ_STAT: rd_mux = {14'h0000, istat_ff};
            CRC_OFF_IRQ_MASK: rd_mux = {14'h0000, imask_ff};
            default: rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (push) begin
            fifo_mem[wptr_ff] <= wdata_i;
        end
    end

    logic [3:0] nxt_wptr;
    logic [3:0] nxt_rptr;
    logic [4:0] nxt_count;
    logic nxt_idle_halt;
    logic [3:0] nxt_plen;
    logic [15:0] nxt_xor;
    logic nxt_go;
    crc_state_type nxt_state;
    logic [15:0] nxt_shreg;
    logic [3:0] nxt_bitcnt;
    logic [15:0] nxt_crc;
    logic [CRC_IRQ_W-1:0] istat_clr;
    logic [CRC_IRQ_W-1:0] nxt_istat;
    logic [CRC_IRQ_W-1:0] nxt_imask;
    logic nxt_irq;
    logic [15:0] nxt_rdata;

    // irq follows the next status so it never lags the sticky bits
    assign istat_clr = wr_istat ? wdata_i[CRC_IRQ_W-1:0] : '0;
    assign nxt_istat = (istat_ff & ~istat_clr) | ev;
    assign nxt_imask = wr_imask ? wdata_i[CRC_IRQ_W-1:0] : imask_ff;
    assign nxt_irq = |(nxt_istat & nxt_imask);
    // unread cycles return zero so stale data never lingers on the bus
    assign nxt_rdata = rd_i ? rd_mux : 16'h0000;

    always_comb begin
        nxt_wptr = wptr_ff;
        nxt_rptr = rptr_ff;
        if (push) begin
            nxt_wptr = wptr_ff + 4'h1;
        end
        if (pop) begin
            nxt_rptr = rptr_ff + 4'h1;
        end
        nxt_count = count_ff + {4'h0, push} - {4'h0, pop};
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wptr_ff <= 4'h0;
            rptr_ff <= 4'h0;
            count_ff <= 5'h00;
        end else begin
            wptr_ff <= nxt_wptr;
            rptr_ff <= nxt_rptr;
            count_ff <= nxt_count;
        end
    end

    always_comb begin
        nxt_idle_halt = idle_halt_ff;
        nxt_plen = plen_ff;
        nxt_xor = xor_ff;
        if (wr_con) begin
            nxt_idle_halt = wdata_i[CRC_B_IDLE];
            nxt_plen = wdata_i[CRC_B_PLEN_LO +: 4];
        end
        if (wr_xor) begin
            nxt_xor = wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            idle_halt_ff <= 1'b0;
            plen_ff <= 4'h0;
            xor_ff <= CRC_RESET_XOR;
        end else begin
            idle_halt_ff <= nxt_idle_halt;
            plen_ff <= nxt_plen;
            xor_ff <= nxt_xor;
        end
    end

    // go stays set while work remains; hardware clears it when the last bit shifts out with the fifo empty
    always_comb begin
        nxt_go = go_ff;
        if (wr_con) begin
            nxt_go = wdata_i[CRC_B_GO];
        end else if (shift_done) begin
            nxt_go = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            go_ff <= 1'b0;
        end else begin
            go_ff <= nxt_go;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_shreg = shreg_ff;
        nxt_bitcnt = bitcnt_ff;
        case (state_ff)
            CRC_ST_IDLE: begin
                if (pop) begin
                    nxt_state = CRC_ST_LOAD;
                end
            end
            CRC_ST_LOAD: begin
                // the read pointer already moved past the popped slot
                if (run_en) begin
                    nxt_shreg = fifo_mem[rptr_ff - 4'h1];
                    nxt_bitcnt = 4'h0;
                    nxt_state = CRC_ST_SHIFT;
                end
            end
            CRC_ST_SHIFT: begin
                if (shift_step) begin
                    nxt_shreg = {shreg_ff[14:0], 1'b0};
                    nxt_bitcnt = bitcnt_ff + 4'h1;
                    if (last_bit) begin
                        nxt_state = CRC_ST_IDLE;
                    end
                end
            end
            default: nxt_state = CRC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff <= CRC_ST_IDLE;
            shreg_ff <= 16'h0000;
            bitcnt_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            shreg_ff <= nxt_shreg;
            bitcnt_ff <= nxt_bitcnt;
        end
    end

    // a result write wins and holds the shifter for that cycle
    always_comb begin
        nxt_crc = crc_ff;
        if (wr_res) begin
            nxt_crc = wdata_i;
        end else if (shift_step) begin
            nxt_crc = crc_shift;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            crc_ff <= 16'h0000;
        end else begin
            crc_ff <= nxt_crc;
        end
    end

    // one sticky cell per event; set wins over a same-cycle clear
    for (genvar gi = 0; gi < CRC_IRQ_W; gi++) begin : g_stat
        crc_sticky_bit #(
            .RESET_VAL(1'b0)
        ) u_stat (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .set_i(ev[gi]),
            .clr_i(istat_clr[gi]),
            .q_o(istat_ff[gi])
        );
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            imask_ff <= '0;
        end else begin
            imask_ff <= nxt_imask;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= nxt_irq;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rdata_o = rdata_ff;
    assign irq_o = irq_ff;
endmodule

module crc_sticky_bit
    import crc_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic q_o
);
    logic bit_ff;
    // a clear in the event's own cycle must not lose the event
    wire logic nxt_bit = set_i | (bit_ff & ~clr_i);

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            bit_ff <= RESET_VAL;
        end else begin
            bit_ff <= nxt_bit;
        end
    end

    assign q_o = bit_ff;
endmodule

// ---- src/crc_pkg.sv ----
package crc_pkg;
    localparam int CRC_DW = 16;
    localparam int CRC_AW = 4;
    // register byte offsets
    localparam logic [3:0] CRC_OFF_CON = 4'h0;
    localparam logic [3:0] CRC_OFF_DATA = 4'h4;
    localparam logic [3:0] CRC_OFF_RESULT = 4'h8;
    localparam logic [3:0] CRC_OFF_XOR = 4'hC;
    localparam logic [3:0] CRC_OFF_IRQ_STAT = 4'h2;
    localparam logic [3:0] CRC_OFF_IRQ_MASK = 4'h3;
    // control/status field positions
    localparam int CRC_B_IDLE = 13;
    localparam int CRC_B_CNT_LO = 8;
    localparam int CRC_B_FULL = 7;
    localparam int CRC_B_EMPTY = 6;
    localparam int CRC_B_GO = 4;
    localparam int CRC_B_PLEN_LO = 0;
    // interrupt status bits
    localparam int CRC_IRQ_DONE = 0;
    localparam int CRC_IRQ_EMPTY = 1;
    localparam int CRC_IRQ_W = 2;
    // fifo depth limits and xor reset value
    localparam logic [4:0] CRC_DEPTH_WIDE = 5'h08;
    localparam logic [4:0] CRC_DEPTH_NARROW = 5'h10;
    localparam logic [3:0] CRC_PLEN_WIDE_MIN = 4'h8;
    localparam logic [15:0] CRC_RESET_XOR = 16'h0000;
    typedef enum logic [1:0] {
        CRC_ST_IDLE = 2'b00,
        CRC_ST_LOAD = 2'b01,
        CRC_ST_SHIFT = 2'b10
    } crc_state_type;
endpackage

// ---- tb/crc_ctrl_props.sv ----
`timescale 1ns/1ps
module crc_ctrl_props (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [3:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] rdata_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire [4:0] cnt = rdata_o[12:8];
    logic ctl_rd_ff;
    logic fresh_ff;
    always_ff @(posedge clk_i) begin
        ctl_rd_ff <= rd_i && addr_i == 4'h0 && !sys_rst_i;
        fresh_ff <= sys_rst_i || (fresh_ff && !wr_i);
    end
    data_idle_a: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not idle");
    count_max_a: assert property (ctl_rd_ff |-> cnt <= 5'h10)
        else $error("word count too large");
    depth_wide_a: assert property (ctl_rd_ff && rdata_o[3] |-> cnt <= 5'h08)
        else $error("wide depth exceeded");
    full_flag_a: assert property (ctl_rd_ff |->
        rdata_o[7] == (cnt >= (rdata_o[3] ? 5'h08 : 5'h10)))
        else $error("full flag wrong");
    empty_flag_a: assert property (ctl_rd_ff |-> rdata_o[6] == (cnt == 5'h00))
        else $error("empty flag wrong");
    reset_empty_a: assert property (ctl_rd_ff && fresh_ff |-> rdata_o == 16'h0040)
        else $error("control reset value wrong");
    irq_reset_a: assert property ($fell(sys_rst_i) |-> !irq_o)
        else $error("irq high after reset");
endmodule

// ---- tb/tb_crc_ctrl.sv ----
`timescale 1ns/1ps
module tb_crc_ctrl;
    logic clk_i = 0, sys_rst_i = 1, cpu_idle_i = 0, wr_i = 0, rd_i = 0, seen = 0;
    logic irq_o;
    logic [3:0] addr_i = 0;
    logic [15:0] wdata_i = 0, rdata_o, last;
    logic [15:0] px, cx, d0, d1;
    logic [31:0] q[$];
    logic [31:0] n;
    int n_errors = 0, cmp_count = 0;
    crc_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cpu_idle_i(cpu_idle_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .irq_o(irq_o));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    // read data lands one cycle after the strobe; mask 0 means poll only
    always @(posedge clk_i) begin
        if (seen) begin
            last = rdata_o;
            n = q.pop_front();
            if (n[31:16] != 0) chk("rdata", n[15:0], rdata_o & n[31:16]);
        end
        seen = rd_i;
    end
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        q.push_back({m, e});
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask
    // reference shifter: order n, msb-first, feedback from the top result bit
    function automatic logic [15:0] ref_crc(input logic [15:0] c, input logic [15:0] p,
            input logic [15:0] d, input int n);
        logic [15:0] m;
        logic fb;
        m = 16'hFFFF >> (16 - n);
        for (int i = n - 1; i >= 0; i--) begin
            fb = c[n - 1] ^ d[i];
            c = ((c << 1) ^ (fb ? p : 16'h0000)) & m;
        end
        return c;
    endfunction
    task automatic poll();
        repeat (200) begin
            rd(4'h0, 16'h0000, 16'h0000);
            @(posedge clk_i);
            @(negedge clk_i);
            if (last[4] === 1'b0) break;
        end
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk_i);
        chk("irq", {15'h0, v}, {15'h0, irq_o});
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(25941));
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(4'h0, 16'hFFFF, 16'h0040);
        rd(4'hE, 16'hFFFF, 16'h0000);
        $display("reset test done");
        wr(4'h0, 16'h000F);
        repeat (9) wr(4'h4, 16'($urandom));
        rd(4'h0, 16'hFFFF, 16'h088F);
        cpu_idle_i <= 1'b1;
        wr(4'h0, 16'h001F);
        poll();
        rd(4'h0, 16'hFFFF, 16'h004F);
        rd(4'h2, 16'hFFFF, 16'h0003);
        $display("wide depth test done");
        irq_is(1'b0);
        wr(4'h3, 16'h0003);
        irq_is(1'b1);
        wr(4'h2, 16'h0003);
        irq_is(1'b0);
        $display("irq test done");
        // one word past the narrow depth must be dropped
        wr(4'h0, 16'h0007);
        repeat (17) wr(4'h4, 16'($urandom));
        rd(4'h0, 16'hFFFF, 16'h1087);
        wr(4'h0, 16'h2017);
        repeat (50) @(posedge clk_i);
        rd(4'h0, 16'hFFFF, 16'h3097);
        cpu_idle_i <= 1'b0;
        poll();
        rd(4'h0, 16'hFFFF, 16'h2047);
        $display("idle halt test done");
        px = 16'($urandom);
        cx = 16'($urandom);
        d0 = 16'($urandom);
        d1 = 16'($urandom);
        wr(4'hC, px);
        wr(4'h8, cx);
        rd(4'hC, 16'hFFFF, px);
        rd(4'h8, 16'hFFFF, cx);
        wr(4'h0, 16'h000B);
        wr(4'h4, d0);
        wr(4'h4, d1);
        wr(4'h0, 16'h001B);
        poll();
        rd(4'h8, 16'hFFFF, ref_crc(ref_crc(cx, px, d0, 12), px, d1, 12));
        $display("crc order test done");
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        complete_run();
    end
endmodule
bind crc_ctrl crc_ctrl_props u_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .rd_i(rd_i), .wr_i(wr_i), .rdata_o(rdata_o), .irq_o(irq_o));
